/* File: sfpr_top.sv */
// Supply and ground supervision, fail-safe entry, power-on-reset flag and retry control
//
// Functional notes
// R1 - Logic supply lost with fail-safe enable set: enter fail-safe, clear serial registers.
// R2 - Fail-safe after logic supply loss: channels follow direct inputs if supply normal.
// R3 - Without logic supply faults still reach fault pin; data out and sensing off.
// R4 - Logic supply lost with enable clear: stay under serial-port control.
// R5 - Supply undervoltage with logic supply fine: serial port keeps responding.
// R6 - Controller holds reset/wake line high during supply undervoltage.
// R7 - Supply above maximum operating level leaves serial port unaffected.
// R8 - Controller should run power-on-reset when supply returns to range.
// R9 - Awake: power-on-reset when one supply rises while the other stays low.
// R10 - Power-on-reset flag also set on wake-up with a supply already up.
// R11 - No power-on-reset when supply recovers while logic supply stayed up.
// R12 - Ground lost but ground reads low: keep normal operation and serial port.
// R13 - Ground lost and ground reads high: serial link lost, enter fail-safe.
// R14 - Ground fail-safe: channel on only when its input is tied to supply.
// R15 - Retry enabled: faulted channel is turned back on periodically.
// R16 - Only latchable faults retry: overcurrent, short, overtemperature, undervoltage.
// R17 - Undervoltage and overtemperature retry begins only after the cause is gone.
// R18 - Retry behaviour from four configuration bits and remaining retry count.
// R19 - Retry disabled: latchable fault latches at once until delatched.
// R20 - Retry enabled only when retry select bit equals load type select.
// R21 - Limited retry keeps retrying while 4-bit counter has not passed fifteen.
// R22 - Supply and ground comparators are synchronised before any decision.
`timescale 1ns/10ps
module sfpr_top #(
   parameter int RETRY_BASE = sfpr_pkg::RETRY_BASE_CYC
) (
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Serial port clock domain
   input wire logic spi_clk_i,
   input wire logic cfg_wr_i,
   input wire sfpr_pkg::sfpr_cfg_t cfg_wdata_i,
   output sfpr_pkg::sfpr_cfg_t cfg_rdata_o,
   // Supply and ground comparators, direct inputs
   input wire sfpr_pkg::sfpr_mon_t mon_i,
   input wire logic [sfpr_pkg::NCH-1:0] dir_in_i,
   input wire logic [sfpr_pkg::NCH-1:0] load_type_select_i,
   // Per-channel fault flags and control
   input wire sfpr_pkg::sfpr_flt_t [sfpr_pkg::NCH-1:0] flt_i,
   input wire logic [sfpr_pkg::NCH-1:0] spi_on_i,
   input wire logic delatch_i,
   input wire logic status_read_i,
   // Channel and pin outputs
   output logic [sfpr_pkg::NCH-1:0] channel_on_o,
   output logic fault_status_low_o,
   output logic failsafe_output_low_o,
   output logic so_enable_o,
   output logic sense_enable_o,
   output logic spi_respond_o,
   output logic spi_regs_clear_o,
   // Status
   output logic failsafe_o,
   output logic por_flag_o,
   output logic [sfpr_pkg::NCH-1:0] retry_full_o,
   output logic [sfpr_pkg::NCH*sfpr_pkg::CNT_W-1:0] retry_count_o
);
   import sfpr_pkg::*;

   // ----------------------------------------------------------------------
   // Serial clock domain: configuration store
   // ----------------------------------------------------------------------
   sfpr_cfg_t spi_cfg_reg;
   logic spi_tog_reg;
   logic spi_clr_s1_reg;
   logic spi_clr_s2_reg;
   logic clr_lvl_reg;

   // Clear request arrives from the system domain as a level
   always_ff @(posedge spi_clk_i) begin
      spi_clr_s1_reg <= clr_lvl_reg;
      spi_clr_s2_reg <= spi_clr_s1_reg;
   end

   // Write stores the word and flips the toggle announcing it
   always_ff @(posedge spi_clk_i) begin
      if (spi_clr_s2_reg) begin
         spi_cfg_reg <= CFG_RST; // [R1]
         spi_tog_reg <= 1'b0;
      end else if (cfg_wr_i) begin
         spi_cfg_reg <= cfg_wdata_i;
         spi_tog_reg <= ~spi_tog_reg;
      end
   end

   assign cfg_rdata_o = spi_cfg_reg;

   // ----------------------------------------------------------------------
   // Synchronisers into the system domain
   // ----------------------------------------------------------------------
   sfpr_mon_t mon_s1_reg;
   sfpr_mon_t mon_reg;
   logic [NCH-1:0] dir_s1_reg;
   logic [NCH-1:0] dir_reg;
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_s3_reg;

   // Two flops on every comparator and direct input pin, three on the write toggle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mon_s1_reg <= MON_RST;
         mon_reg <= MON_RST;
         dir_s1_reg <= '0;
         dir_reg <= '0;
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end else begin
         mon_s1_reg <= mon_i; // [R22]
         mon_reg <= mon_s1_reg; // [R22]
         dir_s1_reg <= dir_in_i;
         dir_reg <= dir_s1_reg;
         tog_s1_reg <= spi_tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end

   // ----------------------------------------------------------------------
   // System copy of the configuration
   // ----------------------------------------------------------------------
   sfpr_cfg_t cfg_reg;
   logic fs_vdd_reg;
   logic por_pulse;
   wire cfg_take = tog_s2_reg ^ tog_s3_reg;

   // Word is stable in the serial domain when its toggle edge is seen
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || fs_vdd_reg || por_pulse) begin
         cfg_reg <= CFG_RST; // [R1]
      end else if (cfg_take) begin
         cfg_reg <= spi_cfg_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Fail-safe decisions
   // ----------------------------------------------------------------------
   logic fs_gnd_reg;
   wire vdd_lost = ~mon_reg.vdd_ok;
   // Loss with enable clear leaves the block under serial control
   wire fs_vdd_next = vdd_lost & (fs_vdd_reg | cfg_reg.vdd_fail_en); // [R1] [R4]
   // Ground reading high means the link is lost; reading low keeps normal work
   wire fs_gnd_next = mon_reg.gnd_high; // [R12] [R13]
   wire failsafe = fs_vdd_reg | fs_gnd_reg;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         fs_vdd_reg <= 1'b0;
         fs_gnd_reg <= 1'b0;
         clr_lvl_reg <= 1'b1;
      end else begin
         fs_vdd_reg <= fs_vdd_next;
         fs_gnd_reg <= fs_gnd_next;
         clr_lvl_reg <= fs_vdd_next | por_pulse; // [R1]
      end
   end

   // ----------------------------------------------------------------------
   // Power-on-reset detection
   // ----------------------------------------------------------------------
   logic vdd_por_q_reg;
   logic vpwr_por_q_reg;
   logic awake_q_reg;
   logic por_flag_reg;
   wire awake = ~mon_reg.reset_wake_low | (|dir_reg);
   wire vpwr_rise = mon_reg.vpwr_por & ~vpwr_por_q_reg;
   wire vdd_rise = mon_reg.vdd_por & ~vdd_por_q_reg;
   // A supply rising while the other stayed low restarts the device
   wire por_sup = awake & ((vpwr_rise & ~vdd_por_q_reg & ~mon_reg.vdd_por) |
                           (vdd_rise & ~vpwr_por_q_reg & ~mon_reg.vpwr_por)); // [R9] [R11]
   // Wake-up with a supply already up and steady
   wire por_wake = awake & ~awake_q_reg &
                   ((mon_reg.vpwr_por & vpwr_por_q_reg) |
                    (mon_reg.vdd_por & vdd_por_q_reg)); // [R10]
   assign por_pulse = por_sup;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         vdd_por_q_reg <= 1'b0;
         vpwr_por_q_reg <= 1'b0;
         awake_q_reg <= 1'b0;
         por_flag_reg <= 1'b0;
      end else begin
         vdd_por_q_reg <= mon_reg.vdd_por;
         vpwr_por_q_reg <= mon_reg.vpwr_por;
         awake_q_reg <= awake;
         // Setting wins over a status read in the same cycle
         por_flag_reg <= (por_sup | por_wake) | (por_flag_reg & ~status_read_i); // [R9] [R10]
      end
   end

   // ----------------------------------------------------------------------
   // Retry control, one machine per channel
   // ----------------------------------------------------------------------
   logic [NCH-1:0] run_ok;
   logic [NCH-1:0] fault_now;
   logic [NCH-1:0] latched;
   wire uv_flag = mon_reg.vpwr_uv;

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++) begin : g_ch
         sfpr_st_t st_reg;
         sfpr_st_t st_next;
         logic [CNT_W-1:0] cnt_reg;
         logic full_reg;
         logic unl_q_reg;
         logic en_q_reg;
         logic [TMR_W-1:0] tmr_reg;
         logic [TMR_W-1:0] tmr_end;
         wire undervoltage_flag = uv_flag;
         wire [PER_W-1:0] per = cfg_reg.retry_per[ch*PER_W +: PER_W];
         // Enable only when the select bit matches the load type
         wire retry_en = (cfg_reg.retry_sel[ch] == load_type_select_i[ch]); // [R20]
         wire unl = cfg_reg.retry_unl[ch];
         // Only latchable faults form the retry condition
         wire retry_cond = flt_i[ch].overcurrent_flag | flt_i[ch].severe_short_flag |
                           flt_i[ch].overtemperature_flag | undervoltage_flag; // [R16]
         wire cause_lvl = flt_i[ch].overtemperature_flag | undervoltage_flag;
         wire tmr_done = (tmr_reg == tmr_end);
         wire attempt = (st_reg == ST_WAIT_TIME) & tmr_done;
         // Unlimited set, retry disabled, fail-safe or reset restart the count
         wire cnt_clr = failsafe | por_pulse | (unl & ~unl_q_reg) | (en_q_reg & ~retry_en);

         // Period is the base count scaled by the two period bits
         assign tmr_end = TMR_W'(RETRY_BASE) << per; // [R18]
         assign fault_now[ch] = retry_cond;
         assign latched[ch] = (st_reg == ST_LATCH);
         assign run_ok[ch] = (st_reg == ST_RUN);
         assign retry_count_o[ch*CNT_W +: CNT_W] = cnt_reg;
         assign retry_full_o[ch] = full_reg;

         // Next state of the retry machine
         always_comb begin
            st_next = st_reg;
            unique case (st_reg)
               ST_RUN: begin
                  if (retry_cond && !retry_en) begin
                     st_next = ST_LATCH; // [R19]
                  end else if (retry_cond && !unl && full_reg) begin
                     st_next = ST_LATCH; // [R21]
                  end else if (retry_cond) begin
                     st_next = ST_WAIT_CAUSE; // [R15]
                  end
               end
               ST_WAIT_CAUSE: begin
                  if (delatch_i) begin
                     st_next = ST_RUN;
                  end else if (!cause_lvl) begin
                     st_next = ST_WAIT_TIME; // [R17]
                  end
               end
               ST_WAIT_TIME: begin
                  if (delatch_i || tmr_done) begin
                     st_next = ST_RUN; // [R15]
                  end
               end
               ST_LATCH: begin
                  if (delatch_i || (cnt_clr && retry_en)) begin
                     st_next = ST_RUN; // [R19]
                  end
               end
            endcase
         end

         // State, timer and retry counter
         always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
               st_reg <= ST_RUN;
               tmr_reg <= TMR_RST;
               cnt_reg <= CNT_RST;
               full_reg <= 1'b0;
               unl_q_reg <= 1'b0;
               en_q_reg <= 1'b0;
            end else begin
               st_reg <= st_next;
               unl_q_reg <= unl;
               en_q_reg <= retry_en;
               tmr_reg <= (st_reg == ST_WAIT_TIME) ? tmr_reg + 1'b1 : TMR_RST;
               if (cnt_clr) begin
                  cnt_reg <= CNT_RST;
                  full_reg <= 1'b0;
               end else if (attempt && !unl) begin
                  // Last count marks full and grants one final try
                  if (cnt_reg == RETRY_LAST) begin
                     full_reg <= 1'b1; // [R21]
                  end else begin
                     cnt_reg <= cnt_reg + 1'b1; // [R18]
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Channel drive and pins
   // ----------------------------------------------------------------------
   logic [NCH-1:0] ch_on_reg;
   logic fsb_low_reg;
   logic failsafe_output_low_low_reg;
   logic so_en_reg;
   logic sense_en_reg;
   logic respond_reg;
   // Fail-safe: direct inputs rule, gated by a normal supply
   wire [NCH-1:0] fs_drive = dir_reg & {NCH{mon_reg.vpwr_norm}}; // [R2] [R14]
   wire [NCH-1:0] spi_drive = spi_on_i & run_ok & ~fault_now;
   wire [NCH-1:0] ch_next = failsafe ? fs_drive : spi_drive;
   // Faults reach the fault pin whatever the logic supply does
   wire fsb_next = (|fault_now) | (|latched); // [R3]
   // Serial port answers through undervoltage and overvoltage alike
   wire respond_next = mon_reg.vdd_ok & ~fs_gnd_reg; // [R5] [R7] [R13]

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ch_on_reg <= '0;
         fsb_low_reg <= 1'b1;
         failsafe_output_low_low_reg <= 1'b1;
         so_en_reg <= 1'b0;
         sense_en_reg <= 1'b0;
         respond_reg <= 1'b0;
      end else begin
         ch_on_reg <= ch_next;
         fsb_low_reg <= ~fsb_next; // [R3]
         failsafe_output_low_low_reg <= ~failsafe;
         so_en_reg <= respond_next; // [R3]
         sense_en_reg <= mon_reg.vdd_ok & ~failsafe; // [R3]
         respond_reg <= respond_next; // [R5]
      end
   end

   // Output assignments
   assign channel_on_o = ch_on_reg;
   assign fault_status_low_o = fsb_low_reg;
   assign failsafe_output_low_o = failsafe_output_low_low_reg;
   assign so_enable_o = so_en_reg;
   assign sense_enable_o = sense_en_reg;
   assign spi_respond_o = respond_reg;
   assign spi_regs_clear_o = clr_lvl_reg;
   assign failsafe_o = failsafe;
   assign por_flag_o = por_flag_reg;

endmodule // sfpr_top

/* File: sfpr_pkg.sv */
// Shared constants and types of the supply fail-safe, power-on-reset and retry block
package sfpr_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NCH = 2;
   localparam int CNT_W = 4;
   localparam int PER_W = 2;
   localparam int TMR_W = 24;
   localparam logic [CNT_W-1:0] RETRY_LAST = 4'hF;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam logic [TMR_W-1:0] TMR_RST = 24'h000000;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int RETRY_BASE_US = 128;
   localparam int CLK_MHZ = 125;
   localparam int RETRY_BASE_CYC = RETRY_BASE_US * CLK_MHZ;

   // ----------------------------------------------------------------------
   // Configuration written over the serial port
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic vdd_fail_en;
      logic [NCH-1:0] retry_sel;
      logic [NCH-1:0] retry_unl;
      logic [NCH*PER_W-1:0] retry_per;
   } sfpr_cfg_t;
   localparam sfpr_cfg_t CFG_RST = '0;

   // Supply and ground comparator outputs, all asynchronous
   typedef struct packed {
      logic vdd_ok;
      logic vdd_por;
      logic vpwr_por;
      logic vpwr_norm;
      logic vpwr_uv;
      logic gnd_high;
      logic reset_wake_low;
   } sfpr_mon_t;
   localparam sfpr_mon_t MON_RST = '0;

   // Latchable fault flags of one channel
   typedef struct packed {
      logic overcurrent_flag;
      logic severe_short_flag;
      logic overtemperature_flag;
   } sfpr_flt_t;

   // Retry state of one channel
   typedef enum logic [1:0] {
      ST_RUN,
      ST_WAIT_CAUSE,
      ST_WAIT_TIME,
      ST_LATCH
   } sfpr_st_t;

endpackage

/* File: sfpr_assertions.sv */
// Concurrent checks on the ports of the supply fail-safe block
`timescale 1ns/10ps
module sfpr_checker (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Watched inputs and configuration read-back
   input wire sfpr_pkg::sfpr_cfg_t cfg_rdata_o,
   input wire sfpr_pkg::sfpr_mon_t mon_i,
   input wire logic [sfpr_pkg::NCH-1:0] dir_in_i,
   input wire sfpr_pkg::sfpr_flt_t [sfpr_pkg::NCH-1:0] flt_i,
   // Watched outputs
   input wire logic [sfpr_pkg::NCH-1:0] channel_on_o,
   input wire logic failsafe_output_low_o,
   input wire logic so_enable_o,
   input wire logic sense_enable_o,
   input wire logic spi_respond_o,
   input wire logic failsafe_o
);
   import sfpr_pkg::*;
   // ---------------------------------------------------------------
   // Clocking and monitor sequences
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_gnd_high;
      mon_i.gnd_high [*3];
   endsequence
   sequence s_vdd_lost;
      (!mon_i.vdd_ok && cfg_rdata_o.vdd_fail_en) [*8];
   endsequence
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_GND_FS: assert property (s_gnd_high |=> failsafe_o)
      else $error("ground high did not enter fail-safe");
   AST_GND_LOST: assert property (mon_i.gnd_high [*5] |-> !spi_respond_o)
      else $error("serial port still answers after ground loss");
   AST_VDD_FS: assert property (s_vdd_lost |-> failsafe_o)
      else $error("logic supply loss did not enter fail-safe");
   AST_FAILSAFE_OUTPUT_LOW: assert property (failsafe_output_low_o == !$past(failsafe_o))
      else $error("fail-safe pin does not follow fail-safe state");
   AST_FS_DIR: assert property
      ((failsafe_o && mon_i.vpwr_norm && dir_in_i == 2'h3) [*4] |-> channel_on_o == 2'h3)
      else $error("channels do not follow direct inputs in fail-safe");
   AST_FS_OFF: assert property
      ((failsafe_o && dir_in_i == 2'h0) [*4] |-> channel_on_o == 2'h0)
      else $error("channel on with low direct input in fail-safe");
   AST_NO_SO: assert property
      ((!mon_i.vdd_ok) [*5] |-> !so_enable_o && !sense_enable_o)
      else $error("data out or sensing enabled without logic supply");
   AST_RESPOND: assert property
      ((mon_i.vdd_ok && mon_i.vdd_por && !mon_i.gnd_high && !mon_i.reset_wake_low) [*5]
       |-> spi_respond_o)
      else $error("serial port not answering with logic supply good");
   AST_FAULT_OFF: assert property
      ((|flt_i[0] && !failsafe_o) |=> !channel_on_o[0] || failsafe_o)
      else $error("channel stayed on with a latchable fault");
endmodule // sfpr_checker

bind sfpr_top sfpr_checker u_chk (
   .clk_sys_i, .rst_i, .cfg_rdata_o, .mon_i, .dir_in_i, .flt_i, .channel_on_o,
   .failsafe_output_low_o, .so_enable_o, .sense_enable_o, .spi_respond_o, .failsafe_o
);

/* File: sfpr_mcu.sv */
// Controller model writing configuration over the serial clock domain
`timescale 1ns/10ps
module sfpr_mcu (
   // Serial side toward the block
   output logic spi_clk_o,
   output logic cfg_wr_o,
   output sfpr_pkg::sfpr_cfg_t cfg_wdata_o
);
   import sfpr_pkg::*;
   // Idle levels, serial clock parked low between frames
   initial begin
      spi_clk_o = 1'b0;
      cfg_wr_o = 1'b0;
      cfg_wdata_o = '0;
   end
   // Runs n serial clock periods of 6 ns
   task automatic clocks(input int n);
      repeat (n) begin
         #3 spi_clk_o = 1'b1;
         #3 spi_clk_o = 1'b0;
      end
   endtask
   // One write frame; word held past the sync window, then driven inverted
   task automatic write(input sfpr_cfg_t w);
      cfg_wdata_o = w;
      // Idle edges first flush a clear level still held in the serial domain
      clocks(2);
      cfg_wr_o = 1'b1;
      clocks(1);
      cfg_wr_o = 1'b0;
      clocks(1);
      #48 cfg_wdata_o = ~w;
   endtask
endmodule // sfpr_mcu

/* File: test_supply_failsafe_por_retry.sv */
// Self-checking bench for the supply fail-safe, power-on-reset and retry block
`timescale 1ns/10ps
module test_supply_failsafe_por_retry;
   import sfpr_pkg::*;
   logic clk_sys_i, rst_i, spi_clk_i, cfg_wr_i, delatch_i, status_read_i;
   sfpr_cfg_t cfg_wdata_i, cfg_rdata_o;
   sfpr_mon_t mon_i;
   sfpr_flt_t [NCH-1:0] flt_i;
   logic [NCH-1:0] dir_in_i, load_type_select_i, spi_on_i, channel_on_o, retry_full_o;
   logic fault_status_low_o, failsafe_output_low_o, so_enable_o, sense_enable_o;
   logic spi_respond_o, spi_regs_clear_o, failsafe_o, por_flag_o;
   logic [NCH*CNT_W-1:0] retry_count_o;
   int miscompares, n_checks;
   // ---------------------------------------------------------------
   // Design, controller model and clock
   // ---------------------------------------------------------------
   sfpr_top #(.RETRY_BASE(4)) uut (
      .clk_sys_i, .rst_i, .spi_clk_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o, .mon_i,
      .dir_in_i, .load_type_select_i, .flt_i, .spi_on_i, .delatch_i, .status_read_i,
      .channel_on_o, .fault_status_low_o, .failsafe_output_low_o, .so_enable_o,
      .sense_enable_o, .spi_respond_o, .spi_regs_clear_o, .failsafe_o, .por_flag_o,
      .retry_full_o, .retry_count_o
   );
   sfpr_mcu mcu (.spi_clk_o(spi_clk_i), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // Waits n edges, then lets their updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic pulse_flt(input sfpr_flt_t f);
      @(posedge clk_sys_i) flt_i[0] <= f;
      @(posedge clk_sys_i) flt_i[0] <= '0;
   endtask
   task automatic results();
      $display("Checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Limited retry on ch0, each of the three channel fault flags in turn (no undervoltage), up to a full counter
   task automatic t_retry();
      mcu.write(sfpr_cfg_t'(9'h100));
      chk(16'(cfg_rdata_o), 16'h0100);
      @(posedge clk_sys_i) spi_on_i <= 2'h1;
      cyc(6);
      chk(16'(channel_on_o), 16'h1);
      for (int i = 0; i < 16; i++) begin
         pulse_flt(sfpr_flt_t'(3'h4 >> (i % 3)));
         cyc(2);
         chk(16'(channel_on_o), 16'h0);
         cyc(10);
         chk(16'(channel_on_o), 16'h1);
         if (i == 14) chk(16'(retry_count_o[3:0]), 16'h000F);
      end
      chk(16'(retry_full_o), 16'h1);
      $display("Retry test done");
   endtask
   // Retry select against load type, latching while disabled
   task automatic t_latch();
      mcu.write(sfpr_cfg_t'(9'h1C0));
      cyc(6);
      pulse_flt(sfpr_flt_t'(3'h4));
      cyc(12);
      chk(16'({channel_on_o, fault_status_low_o}), 16'h0);
      @(posedge clk_sys_i) delatch_i <= 1'b1;
      @(posedge clk_sys_i) delatch_i <= 1'b0;
      cyc(4);
      chk(16'({channel_on_o, fault_status_low_o}), 16'h3);
      @(posedge clk_sys_i) load_type_select_i <= 2'h3;
      cyc(6);
      pulse_flt(sfpr_flt_t'(3'h2));
      cyc(12);
      chk(16'(channel_on_o), 16'h1);
      // Undervoltage holds the channel off until the cause is gone, then it retries
      @(posedge clk_sys_i) mon_i.vpwr_uv <= 1'b1;
      cyc(20);
      chk(16'({channel_on_o, spi_respond_o}), 16'h1);
      @(posedge clk_sys_i) mon_i.vpwr_uv <= 1'b0;
      cyc(14);
      chk(16'(channel_on_o), 16'h1);
      $display("Latch test done");
   endtask
   // Power-on-reset flag from supply ramps and from wake-up
   task automatic t_por();
      @(posedge clk_sys_i) mon_i.vpwr_por <= 1'b0;
      @(posedge clk_sys_i) status_read_i <= 1'b1;
      @(posedge clk_sys_i) status_read_i <= 1'b0;
      cyc(6);
      @(posedge clk_sys_i) mon_i.vpwr_por <= 1'b1;
      cyc(6);
      chk(16'(por_flag_o), 16'h0);
      @(posedge clk_sys_i) mon_i.vdd_por <= 1'b0;
      @(posedge clk_sys_i) mon_i.vpwr_por <= 1'b0;
      cyc(6);
      @(posedge clk_sys_i) mon_i.vdd_por <= 1'b1;
      cyc(6);
      chk(16'(por_flag_o), 16'h1);
      @(posedge clk_sys_i) mon_i.reset_wake_low <= 1'b1;
      @(posedge clk_sys_i) status_read_i <= 1'b1;
      @(posedge clk_sys_i) status_read_i <= 1'b0;
      cyc(6);
      chk(16'(por_flag_o), 16'h0);
      @(posedge clk_sys_i) mon_i.reset_wake_low <= 1'b0;
      cyc(6);
      chk(16'(por_flag_o), 16'h1);
      @(posedge clk_sys_i) mon_i.vpwr_por <= 1'b1;
      // Supply back in range: controller runs a sleep and wake sequence
      @(posedge clk_sys_i) mon_i.reset_wake_low <= 1'b1;
      @(posedge clk_sys_i) status_read_i <= 1'b1;
      @(posedge clk_sys_i) status_read_i <= 1'b0;
      @(posedge clk_sys_i) mon_i.reset_wake_low <= 1'b0;
      cyc(6);
      chk(16'(por_flag_o), 16'h1);
      $display("Power-on-reset test done");
   endtask
   // Ground loss reading high, then low again
   task automatic t_gnd();
      @(posedge clk_sys_i) mon_i.gnd_high <= 1'b1;
      cyc(6);
      chk(16'({failsafe_o, spi_respond_o, failsafe_output_low_o, channel_on_o}), 16'h10);
      @(posedge clk_sys_i) dir_in_i <= 2'h3;
      cyc(6);
      chk(16'(channel_on_o), 16'h3);
      @(posedge clk_sys_i) mon_i.gnd_high <= 1'b0;
      dir_in_i <= 2'h0;
      cyc(6);
      chk(16'({failsafe_o, spi_respond_o, failsafe_output_low_o}), 16'h3);
      $display("Ground test done");
   endtask
   // Logic supply loss with fail-safe enable clear, then set
   task automatic t_vdd();
      for (int e = 0; e < 2; e++) begin
         mcu.write(sfpr_cfg_t'({e[0], 8'h0F}));
         cyc(8);
         @(posedge clk_sys_i) mon_i.vdd_ok <= 1'b0;
         dir_in_i <= 2'h3;
         cyc(10);
         chk(16'({failsafe_o, so_enable_o, sense_enable_o}), 16'(e * 4));
         if (e == 0) chk(16'(channel_on_o), 16'h1);
         if (e == 1) chk(16'({spi_regs_clear_o, channel_on_o}), 16'h7);
         mcu.clocks(4);
         chk(16'(cfg_rdata_o), e ? 16'h0000 : 16'h000F);
         @(posedge clk_sys_i) mon_i.vdd_ok <= 1'b1;
         dir_in_i <= 2'h0;
         cyc(6);
      end
      $display("Logic supply test done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      mon_i = sfpr_mon_t'(7'h78);
      flt_i = '0;
      dir_in_i = 2'h0;
      load_type_select_i = 2'h0;
      spi_on_i = 2'h0;
      delatch_i = 1'b0;
      status_read_i = 1'b0;
      miscompares = 0;
      n_checks = 0;
      mcu.clocks(4);
      cyc(12);
      chk(16'({channel_on_o, por_flag_o, spi_regs_clear_o}), 16'h1);
      rst_i <= 1'b0;
      cyc(6);
      t_retry();
      t_latch();
      t_por();
      t_gnd();
      t_vdd();
      results();
   end
   initial begin
      #400000;
      miscompares++;
      results();
   end
endmodule // test_supply_failsafe_por_retry
